// ### design/cst_supervisor.sv
// Behaviour
// - full power-up tests run before any service
// - crypto blocked until all known-answer tests pass
// - test failure: error state, code AAO1, bits
// - in error only status requests are served
// - crc16 over code image checked at power-up
// - aes ecb/ofb encrypt and decrypt tests
// - aes cmac known-answer test at power-up
// - new firmware accepted only with valid cmac
// - random value compared with previous output
// - powered removal zeroizes traffic, rekey integrity keys
// - unpowered removal zeroizes same keys at boot
// - no output during tests, zeroize, error
// - no key material on any output
// - host id mismatch zeroizes all keys
// - tamper: retention set all, else volatile
`timescale 1ns/1ps
`default_nettype none
`include "cst_params.svh"

module cst_supervisor
  import cst_pkg::*;
#(
  parameter int RNG_W = 64,
  parameter int NUM_KAT = `CST_NUM_KAT
)(
  input wire logic mclk,
  input wire logic resetn,
  input wire cst_code_type codeIn,
  input wire logic [15:0] crcExpected,
  input wire logic katDone,
  input wire logic katPass,
  input wire cst_svc_req_type svcReq,
  input wire logic fwLoadValid,
  input wire logic fwTagOk,
  input wire logic rngValid,
  input wire logic [RNG_W-1:0] rngValue,
  input wire logic tamperActive,
  input wire logic staticTamper,
  input wire logic hostIdValid,
  input wire logic hostIdMatch,
  input wire logic keyRetention,
  input wire logic zeroizeDone,
  output logic katStart,
  output logic [2:0] katSel,
  output logic cryptoEnable,
  output logic dataOutEnable,
  output logic busy,
  output logic svcGrant,
  output cst_svc_rsp_type svcRsp,
  output logic fwAccept,
  output logic fwReject,
  output logic rngAccept,
  output logic zeroizeReq,
  output logic [3:0] zeroizeScope
);
  generate
    if (RNG_W < 1 || NUM_KAT != `CST_NUM_KAT) begin : g_bad
      $error("cst_supervisor: unsupported parameter values");
    end
  endgenerate
  // ----------------------------------------------------------------
  // firmware crc engine
  // ----------------------------------------------------------------
  cst_state_type state_q, state_d;
  logic [15:0] crcValue;
  cst_crc16 u_crc (
    .mclk(mclk),
    .resetn(resetn),
    .clear(state_q == ST_RESET),
    .byteValid(codeIn.valid && state_q == ST_CRC),
    .byteIn(codeIn.data),
    .crc(crcValue)
  );

  // ----------------------------------------------------------------
  // zeroization requests
  // ----------------------------------------------------------------
  logic tamperPrev_q, tamperPrev_d;
  logic zeroReq_q, zeroReq_d;
  logic [3:0] zeroScope_q, zeroScope_d;
  logic [3:0] zeroEvt;
  always_comb begin
    zeroEvt = 4'h0;
    if (tamperActive && !tamperPrev_q) begin
      zeroEvt[`CST_ZB_TRAFFIC] = 1'b1;
      zeroEvt[`CST_ZB_REKEY] = 1'b1;
      if (keyRetention) begin
        zeroEvt[`CST_ZB_ALL] = 1'b1;
      end else begin
        zeroEvt[`CST_ZB_VOLATILE] = 1'b1;
      end
    end
    if (state_q == ST_BOOT && staticTamper) begin
      zeroEvt[`CST_ZB_TRAFFIC] = 1'b1;
      zeroEvt[`CST_ZB_REKEY] = 1'b1;
    end
    if (hostIdValid && !hostIdMatch) begin
      zeroEvt[`CST_ZB_ALL] = 1'b1;
    end
  end
  // a new event in the done cycle starts a fresh request: set wins
  always_comb begin
    tamperPrev_d = tamperActive;
    zeroReq_d = zeroReq_q;
    zeroScope_d = zeroScope_q | zeroEvt;
    if (zeroReq_q && zeroizeDone) begin
      zeroScope_d = zeroEvt;
      zeroReq_d = |zeroEvt;
    end else if (|zeroEvt) begin
      zeroReq_d = 1'b1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      tamperPrev_q <= 1'b0;
      zeroReq_q <= 1'b0;
      zeroScope_q <= 4'h0;
    end else begin
      tamperPrev_q <= tamperPrev_d;
      zeroReq_q <= zeroReq_d;
      zeroScope_q <= zeroScope_d;
    end
  end
  // ----------------------------------------------------------------
  // self-test sequencer
  // ----------------------------------------------------------------
  logic katWait_q, katWait_d;
  logic [2:0] katSel_q, katSel_d;
  logic katStart_q, katStart_d;
  logic [6:0] failBits_q, failBits_d;
  logic [1:0] condFail_q, condFail_d;
  logic [RNG_W-1:0] rngPrev_q, rngPrev_d;
  logic rngHave_q, rngHave_d;
  logic rngAccept_q, rngAccept_d;
  logic fwAccept_q, fwAccept_d;
  logic fwReject_q, fwReject_d;
  always_comb begin
    state_d = state_q;
    katWait_d = katWait_q;
    katSel_d = katSel_q;
    katStart_d = 1'b0;
    failBits_d = failBits_q;
    condFail_d = condFail_q;
    rngPrev_d = rngPrev_q;
    rngHave_d = rngHave_q;
    rngAccept_d = 1'b0;
    fwAccept_d = 1'b0;
    fwReject_d = 1'b0;
    unique case (state_q)
      ST_RESET: begin
        state_d = ST_CRC;
      end
      ST_CRC: begin
        if (codeIn.valid && codeIn.last) begin
          state_d = ST_CRCCHK;
        end
      end
      ST_CRCCHK: begin
        failBits_d[`CST_BIT_CRC] = (crcValue != crcExpected);
        katSel_d = `CST_KAT_ECB_ENC;
        katWait_d = 1'b0;
        state_d = ST_KAT;
      end
      ST_KAT: begin
        // all tests run even after a failure so every bit is known
        if (!katWait_q) begin
          katStart_d = 1'b1;
          katWait_d = 1'b1;
        end else if (katDone) begin
          failBits_d[katSel_q + 3'(`CST_BIT_KAT0)] = !katPass;
          katWait_d = 1'b0;
          if (katSel_q == `CST_KAT_SHA) begin
            state_d = ST_BOOT;
          end else begin
            katSel_d = katSel_q + 3'h1;
          end
        end
      end
      ST_BOOT: begin
        state_d = (|failBits_q) ? ST_ERROR : ST_READY;
      end
      ST_READY: begin
        if (fwLoadValid) begin
          fwAccept_d = fwTagOk;
          fwReject_d = !fwTagOk;
          condFail_d[`CST_COND_FWLOAD] = !fwTagOk;
        end
        if (rngValid) begin
          rngPrev_d = rngValue;
          rngHave_d = 1'b1;
          if (rngHave_q && rngValue == rngPrev_q) begin
            condFail_d[`CST_COND_RNG] = 1'b1;
            state_d = ST_ERROR;
          end else begin
            rngAccept_d = 1'b1;
          end
        end
      end
      ST_ERROR: begin
        state_d = ST_ERROR;
      end
      default: begin
        state_d = ST_ERROR;
      end
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q <= ST_RESET;
      katWait_q <= 1'b0;
      katSel_q <= 3'h0;
      katStart_q <= 1'b0;
      failBits_q <= 7'h00;
      condFail_q <= 2'h0;
      rngPrev_q <= '0;
      rngHave_q <= 1'b0;
      rngAccept_q <= 1'b0;
      fwAccept_q <= 1'b0;
      fwReject_q <= 1'b0;
    end else begin
      state_q <= state_d;
      katWait_q <= katWait_d;
      katSel_q <= katSel_d;
      katStart_q <= katStart_d;
      failBits_q <= failBits_d;
      condFail_q <= condFail_d;
      rngPrev_q <= rngPrev_d;
      rngHave_q <= rngHave_d;
      rngAccept_q <= rngAccept_d;
      fwAccept_q <= fwAccept_d;
      fwReject_q <= fwReject_d;
    end
  end
  // ----------------------------------------------------------------
  // service gate and status answers
  // ----------------------------------------------------------------
  logic cryptoEn_q, cryptoEn_d;
  logic dataEn_q, dataEn_d;
  logic busy_q, busy_d;
  logic grant_q, grant_d;
  cst_svc_rsp_type rsp_q, rsp_d;
  logic isStatus;
  always_comb begin
    isStatus = svcReq.cmd == `CST_CMD_STATUS;
    cryptoEn_d = state_d == ST_READY;
    dataEn_d = state_d == ST_READY && !zeroReq_d;
    busy_d = state_d != ST_READY && state_d != ST_ERROR;
    grant_d = 1'b0;
    rsp_d = '0;
    if (svcReq.valid) begin
      rsp_d.valid = 1'b1;
      // status carries codes and flags only, never key data
      rsp_d.status.errCode = (state_q == ST_ERROR) ?
        `CST_ERROR_CODE : `CST_ERROR_NONE;
      rsp_d.status.state = state_q;
      rsp_d.status.failBits = failBits_q;
      rsp_d.status.condFail = condFail_q;
      rsp_d.status.zeroScope = zeroScope_q;
      if (isStatus && (state_q == ST_READY || state_q == ST_ERROR)) begin
        rsp_d.accepted = 1'b1;
      end else if (state_q == ST_READY && !zeroReq_q) begin
        rsp_d.accepted = 1'b1;
        grant_d = 1'b1;
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cryptoEn_q <= 1'b0;
      dataEn_q <= 1'b0;
      busy_q <= 1'b1;
      grant_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      cryptoEn_q <= cryptoEn_d;
      dataEn_q <= dataEn_d;
      busy_q <= busy_d;
      grant_q <= grant_d;
      rsp_q <= rsp_d;
    end
  end
  assign katStart = katStart_q;
  assign katSel = katSel_q;
  assign cryptoEnable = cryptoEn_q;
  assign dataOutEnable = dataEn_q;
  assign busy = busy_q;
  assign svcGrant = grant_q;
  assign svcRsp = rsp_q;
  assign fwAccept = fwAccept_q;
  assign fwReject = fwReject_q;
  assign rngAccept = rngAccept_q;
  assign zeroizeReq = zeroReq_q;
  assign zeroizeScope = zeroScope_q;
endmodule : cst_supervisor
`default_nettype wire

// ### design/cst_params.svh
`ifndef CST_PARAMS_SVH
`define CST_PARAMS_SVH

// ----------------------------------------------------------------
// error reporting
// ----------------------------------------------------------------
// ascii "AAO1" returned when a power-up test fails
`define CST_ERROR_CODE 32'h41414f31
`define CST_ERROR_NONE 32'h00000000

// ----------------------------------------------------------------
// power-up test set and failed-test bit positions
// ----------------------------------------------------------------
`define CST_NUM_KAT 6
`define CST_NUM_TESTS 7
`define CST_BIT_CRC 0
`define CST_BIT_KAT0 1
`define CST_KAT_ECB_ENC 3'h0
`define CST_KAT_ECB_DEC 3'h1
`define CST_KAT_OFB_ENC 3'h2
`define CST_KAT_OFB_DEC 3'h3
`define CST_KAT_CMAC 3'h4
`define CST_KAT_SHA 3'h5

// ----------------------------------------------------------------
// conditional failure bits
// ----------------------------------------------------------------
`define CST_COND_RNG 0
`define CST_COND_FWLOAD 1

// ----------------------------------------------------------------
// service commands
// ----------------------------------------------------------------
`define CST_CMD_STATUS 4'h1

// ----------------------------------------------------------------
// zeroization scope mask bits
// ----------------------------------------------------------------
`define CST_ZB_TRAFFIC 0
`define CST_ZB_REKEY 1
`define CST_ZB_ALL 2
`define CST_ZB_VOLATILE 3

// ----------------------------------------------------------------
// firmware crc
// ----------------------------------------------------------------
`define CST_CRC_POLY 16'h1021
`define CST_CRC_INIT 16'hffff

`endif

// ### design/cst_pkg.sv
package cst_pkg;

  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_CRC = 3'h1,
    ST_CRCCHK = 3'h2,
    ST_KAT = 3'h3,
    ST_BOOT = 3'h4,
    ST_READY = 3'h5,
    ST_ERROR = 3'h6
  } cst_state_type;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } cst_code_type;

  typedef struct packed {
    logic valid;
    logic [3:0] cmd;
  } cst_svc_req_type;

  typedef struct packed {
    logic [31:0] errCode;
    logic [2:0] state;
    logic [6:0] failBits;
    logic [1:0] condFail;
    logic [3:0] zeroScope;
  } cst_status_type;

  typedef struct packed {
    logic valid;
    logic accepted;
    cst_status_type status;
  } cst_svc_rsp_type;

endpackage : cst_pkg

// ### design/cst_crc16.sv
`timescale 1ns/1ps
`default_nettype none
`include "cst_params.svh"

module cst_crc16
  import cst_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic byteValid,
  input wire logic [7:0] byteIn,
  output logic [15:0] crc
);

  // ----------------------------------------------------------------
  // msb-first byte update
  // ----------------------------------------------------------------
  function automatic logic [15:0] crcByte(input logic [15:0] c,
                                          input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ `CST_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crcByte

  logic [15:0] crc_q;
  logic [15:0] crc_d;

  always_comb begin
    crc_d = crc_q;
    if (clear) begin
      crc_d = `CST_CRC_INIT;
    end else if (byteValid) begin
      crc_d = crcByte(crc_q, byteIn);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      crc_q <= `CST_CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

  assign crc = crc_q;

endmodule : cst_crc16
`default_nettype wire

// ### test/cst_far_model.sv
`timescale 1ns/1ps
`default_nettype none

// --------
// test engine and key store
// --------
module cst_far_model (
  input wire logic mclk,
  input wire logic katStart,
  input wire logic [2:0] katSel,
  input wire logic [5:0] failMask,
  input wire logic zeroizeReq,
  output logic katDone,
  output logic katPass,
  output logic zeroizeDone
);
  logic [1:0] katCnt = 2'h0;
  logic katBusy = 1'b0;
  logic [1:0] zCnt = 2'h0;
  initial katDone = 1'b0;
  initial katPass = 1'b0;
  initial zeroizeDone = 1'b0;
  always @(posedge mclk) begin
    katDone <= 1'b0;
    // idle level toggles so a stale pass never looks valid
    katPass <= ~katPass;
    if (katStart) begin
      katBusy <= 1'b1;
      katCnt <= 2'h0;
    end else if (katBusy) begin
      katCnt <= katCnt + 2'h1;
      if (katCnt == 2'h2) begin
        katBusy <= 1'b0;
        katDone <= 1'b1;
        katPass <= ~failMask[katSel];
      end
    end
    zeroizeDone <= 1'b0;
    if (zeroizeDone || !zeroizeReq) zCnt <= 2'h0;
    else if (zCnt == 2'h3) zeroizeDone <= 1'b1;
    else zCnt <= zCnt + 2'h1;
  end
endmodule : cst_far_model
`default_nettype wire

// ### test/cst_supervisor_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "cst_params.svh"

// --------
// port checker
// --------
module cst_supervisor_chk
  import cst_pkg::*;
#(
  parameter int RNG_W = 64,
  parameter int NUM_KAT = 6
)(
  input wire logic mclk,
  input wire logic resetn,
  input wire cst_svc_req_type svcReq,
  input wire logic tamperActive,
  input wire logic hostIdValid,
  input wire logic hostIdMatch,
  input wire logic keyRetention,
  input wire logic zeroizeDone,
  input wire logic katDone,
  input wire logic katStart,
  input wire logic [2:0] katSel,
  input wire logic cryptoEnable,
  input wire logic dataOutEnable,
  input wire logic busy,
  input wire cst_svc_rsp_type svcRsp,
  input wire logic zeroizeReq,
  input wire logic [3:0] zeroizeScope
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  AST_TEST_QUIET: assert property (
    busy |-> !cryptoEnable && !dataOutEnable)
    else $error("enabled during tests");
  AST_ZERO_QUIET: assert property (zeroizeReq |-> !dataOutEnable)
    else $error("data out during zeroize");
  AST_ERR_CODE: assert property (
    svcRsp.valid && svcRsp.status.state == ST_ERROR
    |-> svcRsp.status.errCode == `CST_ERROR_CODE)
    else $error("bad error code");
  AST_ERR_REFUSE: assert property (
    svcRsp.valid && svcRsp.status.state == ST_ERROR
    && $past(svcReq.cmd) != `CST_CMD_STATUS |-> !svcRsp.accepted)
    else $error("service accepted in error");
  AST_TAMPER: assert property (
    $rose(tamperActive) && !zeroizeReq |=>
    zeroizeReq && zeroizeScope[1:0] == 2'h3 &&
    zeroizeScope[3:2] == ($past(keyRetention) ? 2'h1 : 2'h2))
    else $error("bad tamper scope");
  AST_MISMATCH: assert property (hostIdValid && !hostIdMatch |=>
    zeroizeReq && zeroizeScope[`CST_ZB_ALL]) else $error("no zeroize");
  AST_ZERO_HOLD: assert property (
    zeroizeReq && !zeroizeDone |=> zeroizeReq)
    else $error("zeroize dropped early");
  AST_KAT_STEP: assert property (
    katDone && katSel != `CST_KAT_SHA |=>
    katSel == $past(katSel) + 3'h1 ##1 katStart)
    else $error("bad test step");
endmodule : cst_supervisor_chk

bind cst_supervisor cst_supervisor_chk #(.RNG_W(RNG_W), .NUM_KAT(NUM_KAT))
  u_chk (.mclk, .resetn, .svcReq, .tamperActive, .hostIdValid, .hostIdMatch,
  .keyRetention, .zeroizeDone, .katDone, .katStart, .katSel, .cryptoEnable,
  .dataOutEnable, .busy, .svcRsp, .zeroizeReq, .zeroizeScope);
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "cst_params.svh"

// --------
// supervisor bench
// --------
module testbench
  import cst_pkg::*;
;
  logic mclk, resetn, katDone, katPass, fwLoadValid, fwTagOk, rngValid;
  logic tamperActive, staticTamper, hostIdValid, hostIdMatch, keyRetention;
  logic zeroizeDone, katStart, cryptoEnable, dataOutEnable, busy, svcGrant;
  logic fwAccept, fwReject, rngAccept, zeroizeReq;
  logic [2:0] katSel;
  logic [3:0] zeroizeScope, lastScope;
  logic [5:0] failMask;
  logic [15:0] crcExpected, lfsr;
  logic [63:0] rngValue;
  logic [42:0] expR, gotR;
  logic [42:0] rspQ[$];
  cst_code_type codeIn;
  cst_svc_req_type svcReq;
  cst_svc_rsp_type svcRsp;
  int errors = 0;
  int check_count = 0;
  int kats = 0;

  cst_supervisor dut (.mclk, .resetn, .codeIn, .crcExpected, .katDone,
    .katPass, .svcReq, .fwLoadValid, .fwTagOk, .rngValid, .rngValue,
    .tamperActive, .staticTamper, .hostIdValid, .hostIdMatch, .keyRetention,
    .zeroizeDone, .katStart, .katSel, .cryptoEnable, .dataOutEnable, .busy,
    .svcGrant, .svcRsp, .fwAccept, .fwReject, .rngAccept, .zeroizeReq,
    .zeroizeScope);
  cst_far_model u_far (.mclk, .katStart, .katSel, .failMask, .zeroizeReq,
    .katDone, .katPass, .zeroizeDone);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [15:0] nxt(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt

  // msb first, no reflection
  function automatic logic [15:0] crcB(logic [15:0] c, logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? `CST_CRC_POLY : 16'h0000);
    return c;
  endfunction : crcB

  task automatic chk(string what, logic [42:0] exp, logic [42:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  // expected: {status compared, accepted, errCode, failBits, condFail}
  task automatic svc(logic [3:0] cmd, logic [42:0] exp);
    rspQ.push_back(exp);
    svcReq = '{1'b1, cmd};
    cyc(1);
    svcReq = '0;
    cyc(1);
  endtask : svc

  task automatic waitZ();
    for (int i = 0; i < 50 && zeroizeReq !== 1'b0; i++) cyc(1);
    chk("zeroizeReq", 43'h0, 43'(zeroizeReq));
    cyc(1);
  endtask : waitZ

  task automatic boot(logic bad, logic [5:0] mask, logic [42:0] exp);
    logic [15:0] c;
    c = `CST_CRC_INIT;
    failMask = mask;
    kats = 0;
    resetn = 1'b0;
    cyc(20);
    resetn = 1'b1; // tests repeat only through reset
    cyc(2);
    svc(`CST_CMD_STATUS, 43'h0);
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      c = crcB(c, lfsr[7:0]);
      codeIn = '{1'b1, i == 7, lfsr[7:0]};
      crcExpected = c ^ {15'h0, bad};
      cyc(1);
    end
    codeIn = '0;
    for (int i = 0; i < 300 && busy !== 1'b0; i++) cyc(1);
    chk("busy", 43'h0, 43'(busy));
    cyc(3);
    chk("kats", 43'd6, 43'(kats));
    svc(`CST_CMD_STATUS, exp);
  endtask : boot

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  always @(negedge mclk) begin
    if (katStart === 1'b1) kats++;
    if (zeroizeReq === 1'b1) lastScope = zeroizeScope;
    if (svcRsp.valid === 1'b1) begin
      expR = (rspQ.size() > 0) ? rspQ.pop_front() : '1;
      gotR = {expR[42], svcRsp.accepted, svcRsp.status.errCode,
        svcRsp.status.failBits, svcRsp.status.condFail};
      if (!expR[42]) gotR[40:0] = '0;
      chk("svcRsp", expR, gotR);
      chk("svcGrant", 43'(expR[41] & ~expR[42]), 43'(svcGrant));
    end
  end

  initial begin
    {codeIn, crcExpected, svcReq, fwLoadValid, fwTagOk, rngValid} = '0;
    {rngValue, tamperActive, staticTamper, hostIdValid, hostIdMatch} = '0;
    {keyRetention, failMask, lastScope} = '0;
    lfsr = 16'h67d6;
    resetn = 1'b0;
    @(negedge mclk);
    boot(1'b0, 6'h00, {2'b11, 41'h0});
    chk("cryptoEnable", 43'h1, 43'(cryptoEnable));
    hostIdMatch = 1'b1;
    hostIdValid = 1'b1;
    svc(4'h2, {2'b01, 41'h0});
    chk("zeroizeReq", 43'h0, 43'(zeroizeReq));
    {hostIdValid, hostIdMatch} = 2'b00;
    fwLoadValid = 1'b1;
    fwTagOk = 1'b1;
    cyc(1);
    chk("fwAccept", 43'h1, 43'(fwAccept));
    fwTagOk = 1'b0;
    cyc(1);
    chk("fwReject", 43'h1, 43'(fwReject));
    fwLoadValid = 1'b0;
    rngValid = 1'b1;
    rngValue = {4{lfsr}};
    cyc(1);
    rngValue = ~rngValue;
    cyc(1);
    rngValid = 1'b0;
    chk("rngAccept", 43'h1, 43'(rngAccept));
    tamperActive = 1'b1;
    cyc(1);
    chk("scope", 43'hb, 43'(zeroizeScope));
    hostIdValid = 1'b1;
    cyc(1);
    hostIdValid = 1'b0;
    cyc(1);
    chk("scope", 43'hf, 43'(zeroizeScope));
    chk("dataOut", 43'h0, 43'(dataOutEnable));
    tamperActive = 1'b0;
    waitZ();
    keyRetention = 1'b1;
    tamperActive = 1'b1;
    cyc(1);
    chk("scope", 43'h7, 43'(zeroizeScope));
    tamperActive = 1'b0;
    waitZ();
    svc(`CST_CMD_STATUS, {2'b11, 39'h0, 2'b10});
    rngValid = 1'b1;
    cyc(1);
    rngValid = 1'b0;
    cyc(2);
    chk("cryptoEnable", 43'h0, 43'(cryptoEnable));
    svc(`CST_CMD_STATUS, {2'b11, `CST_ERROR_CODE, 7'h0, 2'b11});
    svc(4'h2, 43'h0);
    svc(`CST_CMD_STATUS, {2'b11, `CST_ERROR_CODE, 7'h0, 2'b11});
    staticTamper = 1'b1;
    boot(1'b1, 6'h11, {2'b11, `CST_ERROR_CODE, 7'h23, 2'b00});
    chk("bootScope", 43'h3, 43'(lastScope));
    svc(4'h3, 43'h0);
    cyc(3);
    summarize();
  end

  // two boots need well under 2000 cycles
  initial begin
    #200000;
    errors++;
    summarize();
  end
endmodule : testbench
`default_nettype wire
